// *** verilog/tdmdma_port.sv ***
/*
  tdm serial port with chained transmit and receive dma: frame master link on
  bit_clk, word buffers and dma counters on core_clk.
  assumes slot masks, block lengths and multichannel_mode are held steady while
  the link runs; the codec answers in the enabled receive slots.
*/
`include "tdmdma_map.svh"

module tdmdma_port
#(
  parameter int WIDTH = `TDMDMA_SLOT_BITS,
  parameter int DEPTH = `TDMDMA_BUF_DEPTH
)
(
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     bit_clk,
  input  wire logic                     multichannel_mode,
  input  wire logic [15:0]              transmit_channel_enable,
  input  wire logic [15:0]              receive_channel_enable,
  input  wire logic [$clog2(DEPTH):0]   tx_block_len,
  input  wire logic [$clog2(DEPTH):0]   rx_block_len,
  input  wire logic                     tx_wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] tx_wr_addr,
  input  wire logic [WIDTH-1:0]         tx_wr_data,
  input  wire logic                     rx_rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rx_rd_addr,
  output      logic [WIDTH-1:0]         rx_rd_data,
  input  wire logic                     rx_dma_hold,
  output      logic [$clog2(DEPTH):0]   transmit_dma_count,
  output      logic [$clog2(DEPTH):0]   receive_dma_count,
  output      logic                     tx_dma_irq,
  output      logic                     rx_dma_irq,
  output      logic                     rx_overrun,
  output      logic                     receive_frame_sync,
  output      logic                     transmit_data_line,
  input  wire logic                     receive_data_line
);
  import tdmdma_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int FW = $clog2(`TDMDMA_FRAME_BITS);

  // ----------------------------------------
  // state of both domains
  // ----------------------------------------
  typedef struct packed
  {
    tdmdma_fetch_t  fetch;
    logic [CW-1:0]  tx_cnt;
    logic [AW-1:0]  tx_idx;
    logic [WIDTH-1:0] hold_data;
    logic           hold_full;
    logic           hold_tgl;
    logic           take_s1;
    logic           take_s2;
    logic           take_seen;
    logic [CW-1:0]  rx_cnt;
    logic [AW-1:0]  rx_idx;
    logic           post_s1;
    logic           post_s2;
    logic           post_s3;
    logic           post_seen;
    logic           tx_irq;
    logic           rx_irq;
    logic           overrun;
  } tdmdma_core_t;

  typedef struct packed
  {
    logic           mode_s1;
    logic           mode_s2;
    logic [15:0]    ten_s1;
    logic [15:0]    ten_s2;
    logic [15:0]    ren_s1;
    logic [15:0]    ren_s2;
    logic           hold_s1;
    logic           hold_s2;
    logic           hold_seen;
    logic [FW-1:0]  bit_cnt;
    logic [WIDTH-1:0] shift;
    logic           shift_full;
    logic           take_tgl;
    logic           din_s1;
    logic           din_s2;
    logic [WIDTH-1:0] rx_shift;
    logic [WIDTH-1:0] rx_word;
    logic           post_tgl;
    logic           fsync;
    logic           dout;
  } tdmdma_link_t;

  tdmdma_core_t core;
  tdmdma_core_t next_core;
  tdmdma_link_t link;
  tdmdma_link_t next_link;

  logic             lrst_s1;
  logic             lrst_s2;
  logic [WIDTH-1:0] tx_rd_data;
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [WIDTH-1:0] fifo_out_data;
  logic             drain;

  // mask decode, slots grow with codecs
  function automatic logic slot_on(input logic [15:0] mask, input logic [FW-1:0] pos);
    logic [3:0] slot;
    slot = pos[FW-1:4];
    return mask[slot];
  endfunction : slot_on

  // ----------------------------------------
  // buffers and receive queue
  // ----------------------------------------
  tdmdma_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_tx_buf
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (tx_wr_en),
    .wr_addr  (tx_wr_addr),
    .wr_data  (tx_wr_data),
    .rd_en    (core.fetch == FETCH_READ),
    .rd_addr  (core.tx_idx),
    .rd_data  (tx_rd_data)
  );

  // drain stalls while the user holds the receive dma, so the queue really fills
  assign drain = fifo_out_valid && !rx_dma_hold;

  tdmdma_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_rx_buf
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (drain),
    .wr_addr  (core.rx_idx),
    .wr_data  (fifo_out_data),
    .rd_en    (rx_rd_en),
    .rd_addr  (rx_rd_addr),
    .rd_data  (rx_rd_data)
  );

  // rx_word is stable for a whole slot after its toggle, so it is safe to read here
  assign fifo_in_valid = (core.post_s2 != core.post_seen);

  tdmdma_fifo #(.WIDTH(WIDTH), .DEPTH(`TDMDMA_FIFO_DEPTH)) u_rx_fifo
  (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (link.rx_word),
    .out_valid (fifo_out_valid),
    .out_ready (!rx_dma_hold),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------
  // core domain: dma counters and fetch
  // ----------------------------------------
  always_comb
  begin
    next_core = core;
    next_core.tx_irq  = 1'b0;
    next_core.rx_irq  = 1'b0;
    next_core.overrun = 1'b0;
    next_core.take_s1 = link.take_tgl;
    next_core.take_s2 = core.take_s1;
    next_core.post_s1 = link.post_tgl;
    next_core.post_s2 = core.post_s1;
    next_core.post_s3 = core.post_s2;
    // holding frees when link starts next slot
    if (core.take_s2 != core.take_seen)
    begin
      next_core.take_seen = core.take_s2;
      next_core.hold_full = 1'b0;
    end
    unique case (core.fetch)
      FETCH_IDLE:
      begin
        // reload only when holding needs a word
        if (!core.hold_full && (core.take_s2 == core.take_seen) && (tx_block_len != '0))
        begin
          next_core.fetch = FETCH_READ;
          if (core.tx_cnt == '0)
          begin
            next_core.tx_cnt = tx_block_len;
            next_core.tx_idx = '0;
          end
        end
      end
      FETCH_READ:
      begin
        next_core.fetch = FETCH_LOAD;
      end
      FETCH_LOAD:
      begin
        next_core.hold_data = tx_rd_data;
        next_core.hold_full = 1'b1;
        next_core.hold_tgl  = ~core.hold_tgl;
        next_core.tx_cnt    = core.tx_cnt - 1'b1;
        next_core.tx_idx    = core.tx_idx + 1'b1;
        next_core.tx_irq    = (core.tx_cnt == CW'(1));
        next_core.fetch     = FETCH_IDLE;
      end
    endcase
    // receive words queue up; a second toggle before acceptance loses the older word
    if (fifo_in_valid && fifo_in_ready)
    begin
      next_core.post_seen = core.post_s2;
    end
    if ((core.post_s2 != core.post_s3) && (core.post_s3 != core.post_seen))
    begin
      next_core.overrun   = 1'b1;
      next_core.post_seen = core.post_s3;
    end
    if (drain)
    begin
      if (core.rx_cnt <= CW'(1))
      begin
        // receive interrupt and reload at count one, so zero never shows
        next_core.rx_irq = 1'b1;
        next_core.rx_cnt = rx_block_len;
        next_core.rx_idx = '0;
      end
      else
      begin
        next_core.rx_cnt = core.rx_cnt - 1'b1;
        next_core.rx_idx = core.rx_idx + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      core        <= '0;
      // receive starts full, transmit at zero until the first fetch reloads it
      core.rx_cnt <= rx_block_len;
    end
    else
    begin
      core <= next_core;
    end
  end

  assign transmit_dma_count = core.tx_cnt;
  assign receive_dma_count  = core.rx_cnt;
  assign tx_dma_irq         = core.tx_irq;
  assign rx_dma_irq         = core.rx_irq;
  assign rx_overrun         = core.overrun;

  // ----------------------------------------
  // link domain: frame master and shifters
  // ----------------------------------------
  // reset release is carried onto bit_clk; the first stage feeds only the second
  always_ff @(posedge bit_clk)
  begin
    lrst_s1 <= rst_b;
    lrst_s2 <= lrst_s1;
  end

  always_comb
  begin
    logic [FW-1:0] rx_pos;
    logic          slot_end;
    logic          pending;
    rx_pos   = link.bit_cnt - FW'(`TDMDMA_RX_PIN_LAG);
    slot_end = (link.bit_cnt[3:0] == 4'hf);
    pending  = (link.hold_s2 != link.hold_seen);
    next_link = link;
    next_link.mode_s1 = multichannel_mode;
    next_link.mode_s2 = link.mode_s1;
    next_link.ten_s1  = transmit_channel_enable;
    next_link.ten_s2  = link.ten_s1;
    next_link.ren_s1  = receive_channel_enable;
    next_link.ren_s2  = link.ren_s1;
    next_link.hold_s1 = core.hold_tgl;
    next_link.hold_s2 = link.hold_s1;
    next_link.din_s1  = receive_data_line;
    next_link.din_s2  = link.din_s1;
    next_link.fsync   = 1'b0;
    next_link.dout    = 1'b0;
    if (link.mode_s2)
    begin
      // count runs through idle slots to frame end
      next_link.bit_cnt = link.bit_cnt + 1'b1;
      // sync one bit ahead of slot zero
      next_link.fsync = (link.bit_cnt == FW'(`TDMDMA_FRAME_BITS - 1));
      // sixteen bits per slot, msb first
      if (slot_on(link.ten_s2, link.bit_cnt))
      begin
        next_link.dout = link.shift[~link.bit_cnt[3:0]];
        if (slot_end)
        begin
          next_link.shift_full = 1'b0;
        end
      end
      if (slot_on(link.ren_s2, rx_pos))
      begin
        next_link.rx_shift = {link.rx_shift[WIDTH-2:0], link.din_s2};
        if (rx_pos[3:0] == 4'hf)
        begin
          next_link.rx_word  = {link.rx_shift[WIDTH-2:0], link.din_s2};
          next_link.post_tgl = ~link.post_tgl;
        end
      end
    end
    // refill shifter after its last slot, then hold
    if (pending && (!link.shift_full || (link.mode_s2 && slot_end
        && slot_on(link.ten_s2, link.bit_cnt))))
    begin
      next_link.shift      = core.hold_data;
      next_link.shift_full = 1'b1;
      next_link.hold_seen  = link.hold_s2;
      next_link.take_tgl   = ~link.take_tgl;
    end
  end

  always_ff @(posedge bit_clk)
  begin
    if (!lrst_s2)
    begin
      link         <= '0;
      // slot count starts at the last bit so the first frame opens with a sync
      link.bit_cnt <= FW'(`TDMDMA_FRAME_BITS - 1);
    end
    else
    begin
      link <= next_link;
    end
  end

  assign receive_frame_sync = link.fsync;
  assign transmit_data_line = link.dout;

endmodule : tdmdma_port

// *** verilog/tdmdma_map.svh ***
/*
  constants of the tdm serial port dma block: slot geometry, link and core rates,
  default block lengths and slot masks, crossing latencies.
  assumes it is included by bare name from tdmdma_port.
*/
`ifndef TDMDMA_MAP_SVH
`define TDMDMA_MAP_SVH

// ----------------------------------------
// link geometry and rates
// ----------------------------------------
`define TDMDMA_SLOT_BITS       16
`define TDMDMA_FRAME_SLOTS     16
`define TDMDMA_BIT_CLK_HZ      12288000
`define TDMDMA_FRAME_HZ        48000
`define TDMDMA_FRAME_BITS      (`TDMDMA_BIT_CLK_HZ / `TDMDMA_FRAME_HZ)
`define TDMDMA_CORE_CLK_HZ     10000000

// ----------------------------------------
// defaults and latencies
// ----------------------------------------
`define TDMDMA_BLOCK_LEN_RST   5'h05
`define TDMDMA_SLOT_MASK_RST   16'h001f
`define TDMDMA_PREFETCH_WORDS  2
`define TDMDMA_RX_PIN_LAG      8'h03
`define TDMDMA_FIFO_DEPTH      4
`define TDMDMA_BUF_DEPTH       16

`endif

// *** verilog/tdmdma_pkg.sv ***
/*
  types shared by the tdm serial port dma block.
  includes no header; tdmdma_map.svh is included by tdmdma_port only.
*/
package tdmdma_pkg;

  // ----------------------------------------
  // transmit fetch sequencer
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    FETCH_IDLE,
    FETCH_READ,
    FETCH_LOAD
  } tdmdma_fetch_t;

endpackage : tdmdma_pkg

// *** verilog/tdmdma_mem.sv ***
/*
  small word buffer: one write port, one read port, read data from a register.
  assumes both ports run on core_clk; a write and a read of one word in one cycle
  return the old word.
*/
module tdmdma_mem
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output      logic [WIDTH-1:0]         rd_data
);
  import tdmdma_pkg::*;

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] word;
    logic [WIDTH-1:0]            rdata;
  } tdmdma_mem_t;

  tdmdma_mem_t state;
  tdmdma_mem_t next_state;

  always_comb
  begin
    next_state = state;
    if (wr_en)
    begin
      next_state.word[wr_addr] = wr_data;
    end
    if (rd_en)
    begin
      next_state.rdata = state.word[rd_addr];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      // writes land in reset too, so a buffer can be filled before the link starts
      state.word  <= next_state.word;
      state.rdata <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rd_data = state.rdata;

endmodule : tdmdma_mem

// *** verilog/tdmdma_fifo.sv ***
/*
  first-in first-out word queue with valid and ready on both sides.
  assumes one clock; in_ready drops when full, out_valid drops when empty.
*/
module tdmdma_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
)
(
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  import tdmdma_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] word;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 fill;
  } tdmdma_fifo_t;

  tdmdma_fifo_t state;
  tdmdma_fifo_t next_state;

  logic push;
  logic pop;

  assign in_ready  = (state.fill != (PW+1)'(DEPTH));
  assign out_valid = (state.fill != '0);
  assign out_data  = state.word[state.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_state = state;
    if (push)
    begin
      next_state.word[state.wr_ptr] = in_data;
      next_state.wr_ptr = (state.wr_ptr == PW'(DEPTH-1)) ? '0 : state.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_state.rd_ptr = (state.rd_ptr == PW'(DEPTH-1)) ? '0 : state.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_state.fill = state.fill + 1'b1;
    end
    else if (pop && !push)
    begin
      next_state.fill = state.fill - 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule : tdmdma_fifo

// *** sim/tdmdma_port_checker.sv ***
/*
  concurrent checks on the ports of tdmdma_port.
  assumes default widths and a bind into every tdmdma_port instance.
*/
module tdmdma_port_checker
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  input wire logic                   bit_clk,
  input wire logic                   rx_dma_hold,
  input wire logic [15:0]            transmit_channel_enable,
  input wire logic [$clog2(DEPTH):0] tx_block_len,
  input wire logic [$clog2(DEPTH):0] rx_block_len,
  input wire logic [$clog2(DEPTH):0] transmit_dma_count,
  input wire logic [$clog2(DEPTH):0] receive_dma_count,
  input wire logic                   tx_dma_irq,
  input wire logic                   rx_dma_irq,
  input wire logic                   receive_frame_sync,
  input wire logic                   transmit_data_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] since_tx;
  logic [7:0] pos;
  logic       seen;
  logic       held;
  // ------
  // helpers
  // ------
  // back-pressure skews the receive side, so spacing is judged only until the first hold after a reset
  always_ff @(posedge core_clk)
  begin
    held <= rst_b && (held || rx_dma_hold);
    since_tx <= (!rst_b) ? 8'hff : tx_dma_irq ? 8'h00 : since_tx + 8'(since_tx != 8'hff);
  end
  always_ff @(posedge bit_clk)
  begin
    seen <= rst_b && (seen || receive_frame_sync);
    pos <= receive_frame_sync ? 8'h00 : pos + 8'h01;
  end
  // ------
  // core side
  // ------
  a_tx_irq_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    tx_dma_irq |-> transmit_dma_count == 0) else $error("tx irq with count not zero");
  a_tx_irq_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    tx_dma_irq |=> !tx_dma_irq) else $error("tx irq too long");
  a_rx_irq_reload: assert property (@(posedge core_clk) disable iff (!rst_b)
    rx_dma_irq |-> receive_dma_count == rx_block_len && $past(receive_dma_count) == 1)
    else $error("rx irq not on last word");
  a_rx_irq_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    rx_dma_irq |=> !rx_dma_irq) else $error("rx irq too long");
  a_tx_count_step: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(transmit_dma_count) |-> transmit_dma_count + 1'b1 == $past(transmit_dma_count)
    || transmit_dma_count == tx_block_len || transmit_dma_count + 1'b1 == tx_block_len)
    else $error("tx count jumped");
  a_rx_count_step: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(receive_dma_count) |-> receive_dma_count + 1'b1 == $past(receive_dma_count)
    || receive_dma_count == rx_block_len) else $error("rx count jumped");
  a_irq_two_slots: assert property (@(posedge core_clk) disable iff (!rst_b)
    rx_dma_irq && !held && tx_block_len == rx_block_len |-> since_tx >= 8'h14
    && since_tx <= 8'h22) else $error("irqs not two slots apart");
  // ------
  // link side
  // ------
  a_sync_one_bit: assert property (@(posedge bit_clk) disable iff (!rst_b)
    receive_frame_sync |=> !receive_frame_sync) else $error("sync wider than one bit");
  a_frame_period: assert property (@(posedge bit_clk) disable iff (!rst_b)
    receive_frame_sync && seen |-> pos == 8'hff) else $error("frame not 256 bits");
  a_idle_slot_low: assert property (@(posedge bit_clk) disable iff (!rst_b)
    seen && !transmit_channel_enable[pos[7:4]] |-> !transmit_data_line)
    else $error("activity on disabled slot");
endmodule : tdmdma_port_checker

bind tdmdma_port tdmdma_port_checker #(.WIDTH(WIDTH), .DEPTH(DEPTH)) tdmdma_port_checker_inst
(
  .core_clk, .rst_b, .bit_clk, .rx_dma_hold, .transmit_channel_enable, .tx_block_len,
  .rx_block_len, .transmit_dma_count, .receive_dma_count, .tx_dma_irq, .rx_dma_irq,
  .receive_frame_sync, .transmit_data_line
);

// *** sim/tdmdma_codec.sv ***
/*
  behavioural codec at the far end of the tdm link.
  assumes the port is frame master and raises sync one bit before slot 0.
*/
module tdmdma_codec
(
  input wire logic        bit_clk,
  input wire logic        receive_frame_sync,
  input wire logic        transmit_data_line,
  input wire logic [15:0] answer_mask,
  output     logic        receive_data_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  pos = 8'h00;
  logic [7:0]  nxt;
  logic [15:0] w;
  logic [15:0] sh;
  logic [15:0] tx_seen [16];
  logic        live = 1'b0;
  int          since = 0;
  int          frame_bits = 0;
  initial receive_data_line = 1'b0;
  // ------
  // link timing
  // ------
  always @(posedge bit_clk)
  begin
    nxt = receive_frame_sync ? 8'h00 : pos + 8'h01;
    w = {4'ha, nxt[7:4], 8'h5c};
    sh <= {sh[14:0], transmit_data_line};
    if (pos[3:0] == 4'hf)
      tx_seen[pos[7:4]] <= {sh[14:0], transmit_data_line};
    since <= receive_frame_sync ? 1 : since + 1;
    if (receive_frame_sync)
      frame_bits <= since;
    live <= live || receive_frame_sync;
    //
    if ((live || receive_frame_sync) && answer_mask[nxt[7:4]])
      receive_data_line <= w[~nxt[3:0]];
    else
      receive_data_line <= ~receive_data_line;
    pos <= nxt;
  end
endmodule : tdmdma_codec

// *** sim/tb.sv ***
/*
  self-checking bench for tdmdma_port with a codec model on the link.
  assumes default widths; tx buffer is loaded while reset is held.
*/
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("unexpected at %0t: mismatch at line %0d", $time, `__LINE__); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, bit_clk, rst_b, multichannel_mode, tx_wr_en, rx_rd_en, rx_dma_hold;
  logic [15:0] transmit_channel_enable, receive_channel_enable, tx_wr_data, rx_rd_data;
  logic [4:0]  tx_block_len, rx_block_len, transmit_dma_count, receive_dma_count;
  logic [3:0]  tx_wr_addr, rx_rd_addr;
  logic tx_dma_irq, rx_dma_irq, rx_overrun, receive_frame_sync;
  logic transmit_data_line, receive_data_line;
  int   mismatches = 0, compares = 0, cyc = 0, n_tx, n_rx, n_ovr, tx_at, rx_at;

  tdmdma_port tdmdma_port_inst
  (
    .core_clk, .rst_b, .bit_clk, .multichannel_mode, .transmit_channel_enable,
    .receive_channel_enable, .tx_block_len, .rx_block_len, .tx_wr_en, .tx_wr_addr,
    .tx_wr_data, .rx_rd_en, .rx_rd_addr, .rx_rd_data, .rx_dma_hold, .transmit_dma_count,
    .receive_dma_count, .tx_dma_irq, .rx_dma_irq, .rx_overrun, .receive_frame_sync,
    .transmit_data_line, .receive_data_line
  );
  tdmdma_codec tdmdma_codec_inst
  (
    .bit_clk, .receive_frame_sync, .transmit_data_line,
    .answer_mask(receive_channel_enable), .receive_data_line
  );
  // ------
  // clocks and watch
  // ------
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial
  begin
    bit_clk = 1'b0;
    #13.7;
    forever #40.69 bit_clk = ~bit_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (tx_dma_irq === 1'b1)
      tx_at = cyc;
    if (rx_dma_irq === 1'b1)
      rx_at = cyc;
    n_tx += int'(tx_dma_irq === 1'b1);
    n_rx += int'(rx_dma_irq === 1'b1);
    n_ovr += int'(rx_overrun === 1'b1);
    if (cyc == 8000)
    begin
      mismatches++;
      $display("unexpected at %0t: run too long", $time);
      summarize();
    end
  end
  // ------
  // tasks
  // ------
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  // the codec stores slot 15 on the edge that sees sync, so wait for sync to fall
  task automatic sync_tick();
    @(posedge receive_frame_sync);
    @(negedge receive_frame_sync);
    tick();
  endtask : sync_tick
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic run_cfg(input int txl, input int rxl, input logic [15:0] txm,
                         input logic [15:0] rxm);
    int s;
    rst_b = 1'b0;
    tx_block_len = 5'(txl);
    rx_block_len = 5'(rxl);
    transmit_channel_enable = txm;
    receive_channel_enable = rxm;
    tx_wr_en = 1'b1;
    for (s = 0; s < 16; s++)
    begin
      tx_wr_addr = 4'(s);
      tx_wr_data = {12'hc30, 4'(s)};
      tick();
    end
    tx_wr_en = 1'b0;
    rst_b = 1'b1;
    sync_tick();
    sync_tick();
    `CHK(transmit_dma_count, txl - 2)
    `CHK(receive_dma_count, rxl)
    n_tx = 0;
    n_rx = 0;
    sync_tick();
    `CHK(n_tx, 1)
    `CHK(n_rx, 1)
    `CHK(tdmdma_codec_inst.frame_bits, 256)
    if (txl == rxl)
      `CHK(rx_at - tx_at >= 20, 1)
    if (txl == rxl)
      `CHK(rx_at - tx_at <= 126, 1)
    for (s = 0; s < 16; s++)
      `CHK(tdmdma_codec_inst.tx_seen[s], (s < txl ? {12'hc30, 4'(s)} : 16'h0000))
    rx_rd_en = 1'b1;
    for (s = 0; s < rxl; s++)
    begin
      rx_rd_addr = 4'(s);
      tick();
      `CHK(rx_rd_data, ({4'ha, 4'(s), 8'h5c}))
    end
    rx_rd_en = 1'b0;
  endtask : run_cfg
  task automatic hold_rx();
    sync_tick();
    rx_dma_hold = 1'b1;
    n_rx = 0;
    n_tx = 0;
    n_ovr = 0;
    sync_tick();
    sync_tick();
    `CHK(n_ovr > 0, 1)
    `CHK(n_rx, 0)
    `CHK(receive_dma_count, 5)
    `CHK(n_tx, 2)
    rx_dma_hold = 1'b0;
    sync_tick();
    sync_tick();
    `CHK(n_rx > 0, 1)
  endtask : hold_rx
  // ------
  // main sequence
  // ------
  initial
  begin
    rst_b = 1'b0;
    multichannel_mode = 1'b1;
    transmit_channel_enable = 16'h001f;
    receive_channel_enable = 16'h001f;
    tx_block_len = 5'h05;
    rx_block_len = 5'h05;
    tx_wr_en = 1'b0;
    tx_wr_addr = 4'h0;
    tx_wr_data = 16'h0000;
    rx_rd_en = 1'b0;
    rx_rd_addr = 4'h0;
    rx_dma_hold = 1'b0;
    repeat (6) tick();
    rst_b = 1'b1;
    repeat (4) tick();
    run_cfg(5, 5, 16'h001f, 16'h001f);
    hold_rx();
    run_cfg(7, 7, 16'h007f, 16'h007f);
    run_cfg(9, 9, 16'h01ff, 16'h01ff);
    run_cfg(7, 5, 16'h007f, 16'h001f);
    summarize();
  end
endmodule : tb
